/* rtl/dpr_host_ctrl.v */
`timescale 1ns/1ps
`include "dpr_map.vh"
// Overview of operation
// - Write strobe loads range or code by select
// - Joined strobes: fall writes, rise updates
// - Fixed mode: range strapped, select held low (a range sequence begun before it is set keeps select high to its end)
// - Set select first, then raise read
// - Drop update before read after converter read
// - Six range codes; 110 and 111 reserved
module dpr_host_ctrl #(
  parameter ADDR_W = 8,
  parameter CNT_W  = 4
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire              ce,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire [17:0]       code_lines_in,
  output reg  [17:0]       code_lines_out,
  output reg               code_lines_oe_n,
  input  wire [2:0]        range_bits_in,
  output reg  [2:0]        range_bits_out,
  output reg               range_bits_oe_n,
  output reg               write_n,
  output reg               update_strobe,
  output reg               read_en,
  output reg               range_select,
  output reg               async_clear_n
);

  localparam ST_IDLE  = 3'd0;
  localparam ST_SETUP = 3'd1;
  localparam ST_PULSE = 3'd2;
  localparam ST_SEL   = 3'd3;
  localparam ST_UPLOW = 3'd4;
  localparam ST_REL   = 3'd5;
  localparam integer     PHASE_M1   = `DPR_PHASE_CYC - 1;
  localparam [CNT_W-1:0] PHASE_LOAD = PHASE_M1[CNT_W-1:0];

  //////////////////////////////////////////////////////////////////////////
  // Register file.

  reg  [2:0]  state_reg, state_next;
  reg  [2:0]  op_reg;
  reg         port_reg;
  reg         conv_reg;
  reg  [17:0] data_reg;
  reg         fixed_reg;
  reg         err_reg;
  reg  [17:0] rdbk_reg;
  wire        phase_done;
  wire        busy = (state_reg != ST_IDLE);
  wire        wr_take = ce && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire        rd_take = ce && s_axi_arvalid && !s_axi_rvalid;
  wire [2:0]  cmd_op = s_axi_wdata[`DPR_CMD_OP_MSB:`DPR_CMD_OP_LSB];
  wire        cmd_port = s_axi_wdata[`DPR_CMD_PORT_BIT];
  wire        is_cmd = (s_axi_awaddr == `DPR_CMD_OFS);
  reg         cmd_ok;
  reg         map_ok;

  assign s_axi_awready = wr_take;
  assign s_axi_wready  = wr_take;
  assign s_axi_arready = rd_take;

  function [17:0] merge_bytes;
    input [17:0] old;
    input [31:0] val;
    input [3:0]  strb;
    begin
      merge_bytes[7:0]   = strb[0] ? val[7:0]   : old[7:0];
      merge_bytes[15:8]  = strb[1] ? val[15:8]  : old[15:8];
      merge_bytes[17:16] = strb[2] ? val[17:16] : old[17:16];
    end
  endfunction

  function is_write_op;
    input [2:0] op;
    begin
      is_write_op = (op == `DPR_OP_WRITE) || (op == `DPR_OP_WRUPD);
    end
  endfunction

  // A command is refused rather than half-done, so software sees SLVERR.
  always @* begin
    cmd_ok = !busy;
    if ((cmd_op == 3'h0) || (cmd_op > `DPR_OP_WRUPD)) begin
      cmd_ok = 1'b0;
    end else if (fixed_reg && cmd_port) begin
      cmd_ok = 1'b0;
    end else if (cmd_port && is_write_op(cmd_op) &&
                 data_reg[2:0] >= `DPR_RANGE_RSVD) begin
      cmd_ok = 1'b0;
    end
  end

  always @* begin
    map_ok = is_cmd || (s_axi_awaddr == `DPR_DATA_OFS) ||
             (s_axi_awaddr == `DPR_CFG_OFS);
  end

  wire start = wr_take && is_cmd && cmd_ok;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DPR_RESP_OKAY;
      data_reg     <= `DPR_DATA_RST;
      fixed_reg    <= `DPR_CFG_RST;
      err_reg      <= 1'b0;
      op_reg       <= 3'h0;
      port_reg     <= 1'b0;
      conv_reg     <= 1'b0;
    end else if (ce) begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `DPR_RESP_OKAY;
        if (!map_ok || (is_cmd && !cmd_ok)) begin
          s_axi_bresp <= `DPR_RESP_SLVERR;
        end
        if (is_cmd && !cmd_ok) begin
          err_reg <= 1'b1;
        end else if (start) begin
          err_reg  <= 1'b0;
          op_reg   <= cmd_op;
          port_reg <= cmd_port;
          conv_reg <= s_axi_wdata[`DPR_CMD_CONV_BIT];
        end else if (s_axi_awaddr == `DPR_DATA_OFS) begin
          data_reg <= merge_bytes(data_reg, s_axi_wdata, s_axi_wstrb);
        end else if ((s_axi_awaddr == `DPR_CFG_OFS) && s_axi_wstrb[0]) begin
          fixed_reg <= s_axi_wdata[`DPR_CFG_FIXED_BIT];
        end
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `DPR_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `DPR_RESP_OKAY;
        s_axi_rdata  <= 32'h00000000;
        if (s_axi_araddr == `DPR_CMD_OFS) begin
          s_axi_rdata[4:0] <= {conv_reg, port_reg, op_reg};
        end else if (s_axi_araddr == `DPR_DATA_OFS) begin
          s_axi_rdata[17:0] <= data_reg;
        end else if (s_axi_araddr == `DPR_CFG_OFS) begin
          s_axi_rdata[`DPR_CFG_FIXED_BIT] <= fixed_reg;
        end else if (s_axi_araddr == `DPR_STAT_OFS) begin
          s_axi_rdata[`DPR_STAT_BUSY_BIT] <= busy;
          s_axi_rdata[`DPR_STAT_ERR_BIT]  <= err_reg;
        end else if (s_axi_araddr == `DPR_RDBK_OFS) begin
          s_axi_rdata[17:0] <= rdbk_reg;
        end else begin
          s_axi_rresp <= `DPR_RESP_SLVERR;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin sequencer. Each phase lasts the phase time; pins change between
  // phases, or one edge into setup, so that strobe edges never meet a moving select.

  wire rd_op  = (op_reg == `DPR_OP_READ);
  wire wu_op  = (op_reg == `DPR_OP_WRUPD);
  wire two_ph = wu_op || (rd_op && conv_reg);

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:  if (start) state_next = ST_SETUP;
      ST_SETUP: if (phase_done) state_next = ST_PULSE;
      ST_PULSE: if (phase_done) state_next = two_ph ? ST_SEL : ST_REL;
      ST_SEL:   if (phase_done) state_next = ST_UPLOW;
      ST_UPLOW: if (phase_done) state_next = ST_REL;
      ST_REL:   if (phase_done) state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  dpr_phase_timer #(
    .CNT_W (CNT_W)
  ) u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .load    (state_next != state_reg),
    .count   (PHASE_LOAD),
    .done    (phase_done)
  );

  // Command fields land on the starting edge, so pins wait one edge for them.
  wire active     = (state_reg != ST_IDLE) && (state_next != ST_IDLE);
  wire drive_data = is_write_op(op_reg) && active;
  wire in_pulse   = (state_next == ST_PULSE);
  wire in_sel     = (state_next == ST_SEL);
  wire rd_high    = rd_op && (in_pulse || in_sel || state_next == ST_UPLOW);

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg       <= ST_IDLE;
      rdbk_reg        <= 18'h00000;
      code_lines_out  <= 18'h00000;
      code_lines_oe_n <= 1'b1;
      range_bits_out  <= 3'h0;
      range_bits_oe_n <= 1'b1;
      write_n         <= 1'b1;
      update_strobe   <= 1'b0;
      read_en         <= 1'b0;
      range_select    <= 1'b0;
      async_clear_n   <= 1'b1;
    end else if (ce) begin
      state_reg <= state_next;
      // Only the selected port is driven, and nothing while reading.
      code_lines_out  <= data_reg;
      range_bits_out  <= data_reg[2:0];
      code_lines_oe_n <= !(drive_data && !port_reg);
      range_bits_oe_n <= !(drive_data && port_reg && !fixed_reg);
      if (!active) begin
        range_select <= 1'b0;
      end else begin
        range_select <= port_reg;
      end
      write_n <= !(is_write_op(op_reg) && in_pulse);
      // Joined strobes rise together; the rising edge updates.
      update_strobe <= ((op_reg == `DPR_OP_UPDATE) && in_pulse) ||
                       (wu_op && in_sel) ||
                       (rd_op && conv_reg && in_sel);
      read_en       <= rd_high;
      async_clear_n <= !((op_reg == `DPR_OP_CLEAR) && in_pulse);
      if (rd_op && phase_done &&
          ((state_reg == ST_PULSE && !conv_reg) || state_reg == ST_SEL)) begin
        rdbk_reg <= port_reg ? {15'h0000, range_bits_in}
                             : code_lines_in;
      end
    end
  end

endmodule // dpr_host_ctrl

/* rtl/dpr_map.vh */
`ifndef DPR_MAP_VH
`define DPR_MAP_VH

// Register offsets of the controller (byte addresses, one word each).
`define DPR_CMD_OFS      8'h00
`define DPR_DATA_OFS     8'h04
`define DPR_CFG_OFS      8'h08
`define DPR_STAT_OFS     8'h0c
`define DPR_RDBK_OFS     8'h10

// Command register fields.
`define DPR_CMD_OP_MSB   2
`define DPR_CMD_OP_LSB   0
`define DPR_CMD_PORT_BIT 3
`define DPR_CMD_CONV_BIT 4

// Command opcodes.
`define DPR_OP_WRITE     3'h1
`define DPR_OP_UPDATE    3'h2
`define DPR_OP_READ      3'h3
`define DPR_OP_CLEAR     3'h4
`define DPR_OP_WRUPD     3'h5

// Status and configuration fields.
`define DPR_STAT_BUSY_BIT 0
`define DPR_STAT_ERR_BIT  1
`define DPR_CFG_FIXED_BIT 0

// Reset values and the first reserved range code.
`define DPR_CFG_RST      1'b0
`define DPR_DATA_RST     18'h00000
`define DPR_RANGE_RSVD   3'h6

// Bus answers.
`define DPR_RESP_OKAY    2'b00
`define DPR_RESP_SLVERR  2'b10

// Pin timing: every phase of a pin sequence lasts at least this long, except setup, whose pins only change one edge into it.
`define DPR_CLK_NS       25
`define DPR_PHASE_NS     50
`define DPR_PHASE_CYC    ((`DPR_PHASE_NS + `DPR_CLK_NS - 1) / `DPR_CLK_NS)

`endif

/* rtl/dpr_phase_timer.v */
`timescale 1ns/1ps
module dpr_phase_timer #(
  parameter CNT_W = 4
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             ce,
  input  wire             load,
  input  wire [CNT_W-1:0] count,
  output wire             done
);

  reg [CNT_W-1:0] cnt_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= {CNT_W{1'b0}};
    end else if (ce) begin
      if (load) begin
        cnt_reg <= count;
      end else if (cnt_reg != {CNT_W{1'b0}}) begin
        cnt_reg <= cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Done must not look at load: load is built from the state that done
  // itself steers, and the two would form a combinational loop.
  assign done = (cnt_reg == {CNT_W{1'b0}});

endmodule // dpr_phase_timer

/* sim/dpr_dev_model.sv */
`timescale 1ns/1ps
module dpr_dev_model (
  input  wire [17:0] h_code,
  input  wire        h_code_oe_n,
  input  wire [2:0]  h_range,
  input  wire        h_range_oe_n,
  input  wire        write_n,
  input  wire        update_strobe,
  input  wire        read_en,
  input  wire        range_select,
  input  wire        async_clear_n,
  input  wire        fixed_mode,
  input  wire [2:0]  strap,
  output wire [17:0] code_bus,
  output wire [2:0]  range_bus
);
  reg [17:0] code_input_reg, code_output_reg;
  reg [2:0]  range_input_reg, range_output_reg;
  // Zero volts sits at a different code in each range family.
  function [17:0] zc(input [2:0] r);
    zc = r == 3'h5 ? 18'h10000 : r > 3'h1 ? 18'h20000 : 18'h0;
  endfunction
  initial begin
    #1;
    range_input_reg = fixed_mode ? strap : 3'h0;
    range_output_reg = range_input_reg;
    {code_input_reg, code_output_reg} = {2{zc(range_input_reg)}};
  end
  always @(negedge write_n)
    if (!read_en && range_select && !fixed_mode) range_input_reg = range_bus;
    else if (!read_en && !range_select) code_input_reg = code_bus;
  always @(posedge update_strobe or negedge read_en)
    if (!read_en && update_strobe) begin
      code_output_reg = code_input_reg;
      range_output_reg = range_input_reg;
    end
  always @*
    if (!write_n && update_strobe && !read_en && !range_select)
      {code_input_reg, code_output_reg} = {2{code_bus}};
  always @(negedge async_clear_n)
    {code_input_reg, code_output_reg} = {2{zc(range_output_reg)}};
  // Released lines show the inverse so a stale sample cannot pass.
  assign code_bus = !h_code_oe_n ? h_code : (read_en && !range_select) ?
    (update_strobe ? code_output_reg : code_input_reg) : ~h_code;
  assign range_bus = fixed_mode ? strap : !h_range_oe_n ? h_range :
    (read_en && range_select) ? (update_strobe ? range_output_reg :
    range_input_reg) : ~h_range;
endmodule // dpr_dev_model

/* sim/dpr_host_ctrl_assertions.sv */
`timescale 1ns/1ps
module dpr_host_ctrl_assertions (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire code_lines_oe_n,
  input wire range_bits_oe_n,
  input wire write_n,
  input wire update_strobe,
  input wire read_en,
  input wire range_select,
  input wire async_clear_n
);
  default clocking dcb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_ONE_PORT: assert property (code_lines_oe_n || range_bits_oe_n)
    else $error("both ports driven");
  AST_READ_FREE: assert property (
    read_en |-> code_lines_oe_n && range_bits_oe_n)
    else $error("bus driven during read");
  AST_SEL_FIRST: assert property (
    $rose(read_en) |-> $stable(range_select) && write_n)
    else $error("select moved at read start");
  AST_UPD_DROP: assert property (
    $fell(read_en) |-> !update_strobe && !$past(update_strobe))
    else $error("update high at read end");
  AST_WR_DRIVE: assert property (
    !write_n |-> !read_en && $stable(range_select) &&
    (range_select ? !range_bits_oe_n : !code_lines_oe_n))
    else $error("write without driven port");
  AST_WR_PULSE: assert property (
    $fell(write_n) |=> !write_n ##1 write_n)
    else $error("write pulse length");
  AST_EDGE_MODE: assert property (
    $rose(update_strobe) && !read_en |-> write_n)
    else $error("update rose with write low");
  AST_DATA_HOLD: assert property (
    $rose(code_lines_oe_n) |-> $past(write_n))
    else $error("data released at strobe");
  AST_CLR_ALONE: assert property (
    !async_clear_n |-> write_n && !update_strobe && !read_en)
    else $error("clear overlaps another strobe");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while answer pending");
endmodule // dpr_host_ctrl_assertions

/* sim/dpr_host_ctrl_tb.sv */
`timescale 1ns/1ps
`include "dpr_map.vh"
module dpr_host_ctrl_tb;
  reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  reg         s_axi_arvalid, s_axi_rready, fixed, ce;
  reg  [7:0]  s_axi_awaddr, s_axi_araddr;
  reg  [31:0] s_axi_wdata, v;
  reg  [42:0] rows [0:9];
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire        s_axi_rvalid, code_lines_oe_n, range_bits_oe_n, write_n;
  wire        update_strobe, read_en, range_select, async_clear_n;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [17:0] code_lines_in, code_lines_out;
  wire [2:0]  range_bits_in, range_bits_out;
  wire [6:0]  pins = {code_lines_oe_n, range_bits_oe_n, write_n,
                      update_strobe, read_en, range_select, async_clear_n};
  integer     n_errors, compares, k;
  dpr_host_ctrl dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .code_lines_in, .code_lines_out, .code_lines_oe_n,
    .range_bits_in, .range_bits_out, .range_bits_oe_n, .write_n,
    .update_strobe, .read_en, .range_select, .async_clear_n);
  dpr_dev_model dev (.h_code(code_lines_out), .h_code_oe_n(code_lines_oe_n),
    .h_range(range_bits_out), .h_range_oe_n(range_bits_oe_n), .write_n,
    .update_strobe, .read_en, .range_select, .async_clear_n,
    .fixed_mode(fixed), .strap(3'h3), .code_bus(code_lines_in),
    .range_bus(range_bits_in));
  //////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Each bus task opens on a fresh edge so no signal gets two values at once.
  task axw(input [7:0] a, input [31:0] d, input [1:0] er);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (s_axi_awready !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", er, s_axi_bresp);
    end
  endtask
  task axr(input [7:0] a, input [1:0] er);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      v = s_axi_rdata;
      chk("rresp", er, s_axi_rresp);
    end
  endtask
  task op(input [4:0] c, input [1:0] er);
    begin
      axw(`DPR_CMD_OFS, {27'h0, c}, er);
      v = 32'h1;
      while (v[`DPR_STAT_BUSY_BIT] !== 1'b0) axr(`DPR_STAT_OFS, `DPR_RESP_OKAY);
    end
  endtask
  task rb(input [4:0] c, input [17:0] e);
    begin
      op(c, `DPR_RESP_OKAY);
      axr(`DPR_RDBK_OFS, `DPR_RESP_OKAY);
      chk("rdbk", {14'h0, e}, v);
    end
  endtask
  task conclude;
    begin
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors = n_errors + 1;
    conclude;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, fixed} = 5'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0;
    {s_axi_wdata, n_errors, compares} = 0;
    ce = 1'b1;
    rows[0] = {5'h01, `DPR_RESP_OKAY, 18'h2abcd, 18'h0};
    rows[1] = {5'h03, `DPR_RESP_OKAY, 18'h0, 18'h2abcd};
    rows[2] = {5'h13, `DPR_RESP_OKAY, 18'h0, 18'h0};
    rows[3] = {5'h1b, `DPR_RESP_OKAY, 18'h0, 18'h0};
    rows[4] = {5'h02, `DPR_RESP_OKAY, 18'h0, 18'h0};
    rows[5] = {5'h13, `DPR_RESP_OKAY, 18'h0, 18'h2abcd};
    rows[6] = {5'h02, `DPR_RESP_OKAY, 18'h0, 18'h0};
    rows[7] = {5'h13, `DPR_RESP_OKAY, 18'h0, 18'h2abcd};
    rows[8] = {5'h05, `DPR_RESP_OKAY, 18'h00123, 18'h0};
    rows[9] = {5'h13, `DPR_RESP_OKAY, 18'h0, 18'h00123};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`DPR_CFG_OFS, `DPR_RESP_OKAY);
    chk("cfg", 32'h0, v);
    axr(`DPR_STAT_OFS, `DPR_RESP_OKAY);
    chk("stat", 32'h0, v);
    for (k = 0; k < 10; k = k + 1) begin
      axw(`DPR_DATA_OFS, {14'h0, rows[k][35:18]}, `DPR_RESP_OKAY);
      if (rows[k][40:38] == 3'h3)
        rb(rows[k][42:38], rows[k][17:0]);
      else op(rows[k][42:38], rows[k][37:36]);
    end
    for (k = 0; k < 8; k = k + 1) begin
      axw(`DPR_DATA_OFS, k, `DPR_RESP_OKAY);
      op(5'h09, k < 6 ? `DPR_RESP_OKAY : `DPR_RESP_SLVERR);
      if (k < 6) begin
        rb(5'h0b, k[17:0]);
        op(5'h02, `DPR_RESP_OKAY);
        op(5'h04, `DPR_RESP_OKAY);
        rb(5'h13, k == 5 ? 18'h10000 : k > 1 ? 18'h20000 : 18'h0);
        rb(5'h03, k == 5 ? 18'h10000 : k > 1 ? 18'h20000 : 18'h0);
        rb(5'h1b, k[17:0]);
      end
    end
    for (k = 6; k < 9; k = k + 1) op({2'b00, k[2:0]}, `DPR_RESP_SLVERR);
    axw(8'h14, 32'h1, `DPR_RESP_SLVERR);
    axr(8'h14, `DPR_RESP_SLVERR);
    chk("unmapped", 32'h0, v);
    axw(`DPR_CMD_OFS, 32'h1, `DPR_RESP_OKAY);
    axw(`DPR_CMD_OFS, 32'h1, `DPR_RESP_SLVERR);
    op(5'h0, `DPR_RESP_SLVERR);
    chk("stat err", 32'h2, v);
    fixed <= 1'b1;
    axw(`DPR_CFG_OFS, 32'h1, `DPR_RESP_OKAY);
    op(5'h09, `DPR_RESP_SLVERR);
    op(5'h0b, `DPR_RESP_SLVERR);
    rb(5'h03, 18'h00007);
    // A sequence caught in its setup phase must freeze with the enable low.
    axw(`DPR_CMD_OFS, 32'h1, `DPR_RESP_OKAY);
    ce <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("frozen pins", 32'h31, {25'h0, pins});
    ce <= 1'b1;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk("reset pins", 32'h71, {25'h0, pins});
    axr(`DPR_CFG_OFS, `DPR_RESP_OKAY);
    chk("cfg reset", 32'h0, v);
    axr(`DPR_STAT_OFS, `DPR_RESP_OKAY);
    chk("stat reset", 32'h0, v);
    conclude;
  end
endmodule // dpr_host_ctrl_tb

bind dpr_host_ctrl dpr_host_ctrl_assertions u_chk (.aclk, .aresetn,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .code_lines_oe_n,
  .range_bits_oe_n, .write_n, .update_strobe, .read_en, .range_select,
  .async_clear_n);
